// File: rtl/crossing_channel.sv
`timescale 1ns/1ns
`include "thresh_bank_defs.svh"

module crossing_channel (
   input  wire logic                                 clk_i,      // Clock.
   input  wire logic                                 rst_i,      // Reset.
   input  wire thresh_bank_pkg::level_t [`NUM_LEVELS-1:0] levels_i, // Levels.
   input  wire logic [`SEL_W-1:0]                    select_i,   // Pick.
   input  wire thresh_bank_pkg::level_t              sample_i,   // Sample.
   input  wire logic                                 valid_i,    // Strobe.
   input  wire logic [1:0]                           edge_en_i,  // Edges.
   input  wire logic                                 mode_i,     // 1 = ADC.
   output thresh_bank_pkg::level_t                   level_o,    // Level.
   output logic                                      above_o,    // Above.
   output logic                                      crossing_o, // Event.
   output thresh_bank_pkg::level_t                   code_o      // Code.
);

   thresh_bank_pkg::chan_state_s st;
   thresh_bank_pkg::chan_state_s next_st;
   logic                         now_above;

   // Selects the level, compares the sample and flags crossings.
   always_comb begin
      next_st = st;
      next_st.crossing = 1'b0;
      // (RL5) index picks level.
      next_st.level = levels_i[select_i];
      now_above = sample_i > st.level;
      // (RL11) per-input mode.
      if (valid_i && mode_i == `MODE_COMPARATOR) begin
         // (RL10) edge enable gating.
         next_st.crossing =
            (now_above && !st.above && edge_en_i[`EDGE_RISE_BIT]) ||
            (!now_above && st.above && edge_en_i[`EDGE_FALL_BIT]);
         next_st.above = now_above;
      end else if (valid_i) begin
         next_st.code = sample_i;
      end
   end

   // Registers the channel state.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign level_o    = st.level;
   assign above_o    = st.above;
   assign crossing_o = st.crossing;
   assign code_o     = st.code;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   chk_level_pick: assert property ( // (RL5)
      ##1 level_o == $past(levels_i[select_i]))
      else $error("Selected level does not follow the selector.");

   chk_rise_event: assert property ( // (RL10)
      valid_i && mode_i == `MODE_COMPARATOR && edge_en_i[0] &&
      !above_o && sample_i > level_o |=> crossing_o && above_o)
      else $error("Rising crossing not flagged.");

   chk_adc_quiet: assert property ( // (RL11)
      valid_i && mode_i == `MODE_ADC |=> !crossing_o &&
      code_o == $past(sample_i))
      else $error("ADC mode sample mishandled.");

endmodule

// File: rtl/input_threshold_select_bank.sv
`timescale 1ns/1ns
`include "thresh_bank_defs.svh"

// Operation
// (RL1) Register 2Ch bits 19..10 hold threshold seven, read/write.
// (RL2) Register 2Ch bits 9..0 hold threshold six, read/write.
// (RL3) Register 2Dh bits 19..10 hold threshold nine, read/write.
// (RL4) Register 2Dh bits 9..0 hold threshold eight, read/write.
// (RL5) A 3-bit selector value n picks threshold n.
// (RL6) Register 2Eh holds selectors for inputs 0..7, three bits each.
// (RL7) Register 2Fh holds inputs 8..11, group A and B; top bits zero.
// (RL8) Register 30h holds supply sense selectors at bits 20..9.
// (RL9) Thresholds six to nine must be programmed before use.
// (RL10) Selected level drives edge events: none, rising, falling or both.
// (RL11) Each input chooses comparator mode (0) or ADC mode (1).
// (RL12) Reads return last written value; reserved bits ignore writes.
module input_threshold_select_bank (
   input  wire logic                 clk_i,          // Clock, 100 MHz.
   input  wire logic                 rst_i,          // Sync reset, high.
   input  wire logic                 wb_cyc_i,       // Bus cycle.
   input  wire logic                 wb_stb_i,       // Bus strobe.
   input  wire logic                 wb_we_i,        // Write enable.
   input  wire logic [7:0]           wb_adr_i,       // Byte address.
   input  wire logic [3:0]           wb_sel_i,       // Byte enables.
   input  wire logic [31:0]          wb_dat_i,       // Write data.
   output logic [31:0]               wb_dat_o,       // Read data.
   output logic                      wb_ack_o,       // Acknowledge.
   input  wire thresh_bank_pkg::level_t [`NUM_EXT_LEVELS-1:0]
                                     thresh_low_i,   // Levels zero..five.
   output thresh_bank_pkg::level_t   threshold_eight_o, // Level eight.
   output thresh_bank_pkg::level_t   threshold_nine_o,  // Level nine.
   input  wire thresh_bank_pkg::level_t [`NUM_CHAN-1:0]
                                     sample_i,       // Channel samples.
   input  wire logic [`NUM_CHAN-1:0] sample_valid_i, // Sample strobes.
   input  wire logic [`NUM_CHAN-1:0][1:0]
                                     edge_en_i,      // Edge enables.
   input  wire logic [`NUM_CHAN-1:0] mode_i,         // 1 = ADC mode.
   output thresh_bank_pkg::level_t [`NUM_CHAN-1:0]
                                     level_o,        // Selected levels.
   output logic [`NUM_CHAN-1:0]      above_o,        // Above levels.
   output logic [`NUM_CHAN-1:0]      crossing_o,     // Crossing pulses.
   output thresh_bank_pkg::level_t [`NUM_CHAN-1:0]
                                     code_o          // ADC codes.
);

   localparam int SEL_TOTAL = `NUM_CHAN * `SEL_W;

   thresh_bank_pkg::bank_state_s st;
   thresh_bank_pkg::bank_state_s next_st;

   logic                       req;
   logic [5:0]                 idx;
   logic [31:0]                mask;
   logic [31:0]                merged;
   logic [SEL_TOTAL-1:0]       all_sel;
   thresh_bank_pkg::level_t [`NUM_LEVELS-1:0] levels;

   // A new request is one not yet acknowledged.
   assign req = wb_cyc_i && wb_stb_i && !st.ack;
   assign idx = wb_adr_i[7:2];

   // Expands byte enables into a bit mask over the write data.
   always_comb begin
      mask = '0;
      for (int b = 0; b < 4; b++) begin
         mask[8*b +: 8] = {8{wb_sel_i[b]}};
      end
   end

   // Merges the enabled bytes with the addressed register's content.
   always_comb begin
      merged = '0;
      case (idx)
         `IDX_SIX_SEVEN: begin
            merged = {12'h000, st.thr7, st.thr6};
         end
         `IDX_EIGHT_NINE: begin
            merged = {12'h000, st.thr9, st.thr8};
         end
         `IDX_LOW_MAP: begin
            merged = {8'h00, st.map_low};
         end
         `IDX_MID_MAP: begin
            merged = {14'h0000, st.map_mid};
         end
         `IDX_SUPPLY_MAP: begin
            merged = {11'h000, st.map_supply, 9'h000};
         end
         default: begin
            merged = '0;
         end
      endcase
      merged = (merged & ~mask) | (wb_dat_i & mask);
   end

   // Bus slave: one-cycle answer, writes land with the acknowledge.
   always_comb begin
      next_st = st;
      next_st.ack = req;
      if (req && !wb_we_i) begin
         // (RL12) read back stored.
         case (idx)
            `IDX_SIX_SEVEN: begin
               next_st.rdata = {12'h000, st.thr7, st.thr6};
            end
            `IDX_EIGHT_NINE: begin
               next_st.rdata = {12'h000, st.thr9, st.thr8};
            end
            `IDX_LOW_MAP: begin
               next_st.rdata = {8'h00, st.map_low};
            end
            `IDX_MID_MAP: begin
               next_st.rdata = {14'h0000, st.map_mid};
            end
            `IDX_SUPPLY_MAP: begin
               next_st.rdata = {11'h000, st.map_supply, 9'h000};
            end
            default: begin
               next_st.rdata = '0;
            end
         endcase
      end
      if (req && wb_we_i) begin
         case (idx)
            `IDX_SIX_SEVEN: begin
               // (RL1) threshold seven field.
               next_st.thr7 = merged[`LVL_HI_LSB +: `LVL_W];
               // (RL2) threshold six field.
               next_st.thr6 = merged[`LVL_LO_LSB +: `LVL_W];
            end
            `IDX_EIGHT_NINE: begin
               // (RL3) threshold nine field.
               next_st.thr9 = merged[`LVL_HI_LSB +: `LVL_W];
               // (RL4) threshold eight field.
               next_st.thr8 = merged[`LVL_LO_LSB +: `LVL_W];
            end
            `IDX_LOW_MAP: begin
               // (RL6) eight input selectors.
               next_st.map_low = merged[`LOW_MAP_W-1:0];
            end
            `IDX_MID_MAP: begin
               // (RL7) reserved bits dropped.
               next_st.map_mid = merged[`MID_MAP_W-1:0];
            end
            `IDX_SUPPLY_MAP: begin
               // (RL8) supply sense selectors.
               next_st.map_supply =
                  merged[`SUPPLY_MAP_LSB +: `SUPPLY_MAP_W];
            end
            default: begin
               next_st.thr6 = st.thr6;
            end
         endcase
      end
   end

   // Registers the bank; the upper levels reset to zero for determinism.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st.ack        <= 1'b0;
         st.rdata      <= '0;
         // (RL9) no promised value.
         st.thr6       <= `LVL_RST;
         st.thr7       <= `LVL_RST;
         st.thr8       <= `LVL_RST;
         st.thr9       <= `LVL_RST;
         st.map_low    <= `MAP_RST_LOW;
         st.map_mid    <= `MAP_RST_MID;
         st.map_supply <= `MAP_RST_SUPPLY;
      end else begin
         st <= next_st;
      end
   end

   assign wb_ack_o          = st.ack;
   assign wb_dat_o          = st.rdata;
   assign threshold_eight_o = st.thr8;
   assign threshold_nine_o  = st.thr9;

   // Selectors in channel order: inputs 0..11, group A, group B, sense.
   assign all_sel = {st.map_supply, st.map_mid, st.map_low};
   assign levels  = {st.thr7, st.thr6, thresh_low_i};

   // One comparison channel per selector.
   for (genvar c = 0; c < `NUM_CHAN; c++) begin : g_chan
      crossing_channel u_chan (
         .clk_i      (clk_i),
         .rst_i      (rst_i),
         .levels_i   (levels),
         .select_i   (all_sel[c*`SEL_W +: `SEL_W]),
         .sample_i   (sample_i[c]),
         .valid_i    (sample_valid_i[c]),
         .edge_en_i  (edge_en_i[c]),
         .mode_i     (mode_i[c]),
         .level_o    (level_o[c]),
         .above_o    (above_o[c]),
         .crossing_o (crossing_o[c]),
         .code_o     (code_o[c])
      );
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_request;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence s_answer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   sequence s_full_write(logic [5:0] at);
      s_request and (wb_we_i && wb_sel_i == 4'hF && idx == at);
   endsequence

   chk_bus_answer: assert property ( // (RL12)
      s_request |=> s_answer)
      else $error("Bus request not answered in one cycle.");

   chk_seven_field: assert property ( // (RL1)
      s_full_write(`IDX_SIX_SEVEN) |=>
      st.thr7 == $past(wb_dat_i[19:10]))
      else $error("Threshold seven field misplaced.");

   chk_six_field: assert property ( // (RL2)
      s_full_write(`IDX_SIX_SEVEN) |=>
      st.thr6 == $past(wb_dat_i[9:0]))
      else $error("Threshold six field misplaced.");

   chk_nine_field: assert property ( // (RL3)
      s_full_write(`IDX_EIGHT_NINE) |=>
      threshold_nine_o == $past(wb_dat_i[19:10]))
      else $error("Threshold nine field misplaced.");

   chk_eight_field: assert property ( // (RL4)
      s_full_write(`IDX_EIGHT_NINE) |=>
      threshold_eight_o == $past(wb_dat_i[9:0]))
      else $error("Threshold eight field misplaced.");

   chk_low_map: assert property ( // (RL6)
      s_full_write(`IDX_LOW_MAP) |=> ##2
      level_o[7] == levels[$past(wb_dat_i[23:21], 3)])
      else $error("Input seven selector misplaced.");

   chk_mid_reserved: assert property ( // (RL7)
      s_request and (!wb_we_i && idx == `IDX_MID_MAP) |=>
      wb_dat_o[31:18] == 14'h0000)
      else $error("Reserved map bits read nonzero.");

   chk_supply_map: assert property ( // (RL8)
      s_request and (!wb_we_i && idx == `IDX_SUPPLY_MAP) |=>
      wb_dat_o[31:21] == 11'h000 && wb_dat_o[8:0] == 9'h000 &&
      wb_dat_o[20:9] == st.map_supply)
      else $error("Supply map read layout wrong.");

endmodule

// File: rtl/thresh_bank_defs.svh
`ifndef THRESH_BANK_DEFS_SVH
`define THRESH_BANK_DEFS_SVH

// Register indices; the byte address is four times the index.
`define IDX_SIX_SEVEN     6'h2C
`define IDX_EIGHT_NINE    6'h2D
`define IDX_LOW_MAP       6'h2E
`define IDX_MID_MAP       6'h2F
`define IDX_SUPPLY_MAP    6'h30

// Field layout of the two threshold registers.
`define LVL_W             10
`define LVL_HI_LSB        10
`define LVL_LO_LSB        0
`define LVL_RST           10'h000

// Field layout of the selector registers.
`define SEL_W             3
`define LOW_MAP_W         24
`define MID_MAP_W         18
`define SUPPLY_MAP_W      12
`define SUPPLY_MAP_LSB    9
`define MAP_RST_LOW       24'h000000
`define MAP_RST_MID       18'h00000
`define MAP_RST_SUPPLY    12'h000

// Channel counts and encodings.
`define NUM_CHAN          18
`define NUM_LEVELS        8
`define NUM_EXT_LEVELS    6
`define EDGE_RISE_BIT     0
`define EDGE_FALL_BIT     1
`define MODE_COMPARATOR   1'b0
`define MODE_ADC          1'b1

`endif

// File: rtl/thresh_bank_pkg.sv
package thresh_bank_pkg;
`include "thresh_bank_defs.svh"

   typedef logic [`LVL_W-1:0] level_t;

   // State of one comparison channel.
   typedef struct packed {
      level_t level;
      logic   above;
      logic   crossing;
      level_t code;
   } chan_state_s;

   // State of the register bank and its bus slave.
   typedef struct packed {
      logic                     ack;
      logic [31:0]              rdata;
      level_t                   thr6;
      level_t                   thr7;
      level_t                   thr8;
      level_t                   thr9;
      logic [`LOW_MAP_W-1:0]    map_low;
      logic [`MID_MAP_W-1:0]    map_mid;
      logic [`SUPPLY_MAP_W-1:0] map_supply;
   } bank_state_s;

endpackage

// File: test/tb.sv
`timescale 1ns/1ns
`include "thresh_bank_defs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin \
   miscompares++; \
   $display("wrong value at %0t: got %h want %h", $time, g, e); end end

module tb;
   logic                       clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
   logic [7:0]                 wb_adr_i;
   logic [3:0]                 wb_sel_i;
   logic [31:0]                wb_dat_i, wb_dat_o, q;
   logic                       wb_ack_o;
   thresh_bank_pkg::level_t [`NUM_EXT_LEVELS-1:0] thresh_low_i;
   thresh_bank_pkg::level_t    threshold_eight_o, threshold_nine_o;
   thresh_bank_pkg::level_t [`NUM_CHAN-1:0] sample_i, level_o, code_o;
   logic [`NUM_CHAN-1:0]       sample_valid_i, mode_i, above_o, crossing_o;
   logic [`NUM_CHAN-1:0][1:0]  edge_en_i;
   thresh_bank_pkg::level_t    lv [8];
   int                         miscompares, compares;

   // Free-running 100 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   input_threshold_select_bank input_threshold_select_bank_i (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .thresh_low_i(thresh_low_i),
      .threshold_eight_o(threshold_eight_o),
      .threshold_nine_o(threshold_nine_o), .sample_i(sample_i),
      .sample_valid_i(sample_valid_i), .edge_en_i(edge_en_i),
      .mode_i(mode_i), .level_o(level_o), .above_o(above_o),
      .crossing_o(crossing_o), .code_o(code_o));

   wb_host_model wb_host_model_i (
      .clk_i(clk_i), .ack_i(wb_ack_o), .rdat_i(wb_dat_o),
      .cyc_o(wb_cyc_i), .stb_o(wb_stb_i), .we_o(wb_we_i),
      .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));

   // Register access by index; the byte address is four times it.
   task automatic wr(input logic [5:0] i, input logic [31:0] d,
                     input logic [3:0] s);
      wb_host_model_i.xfer(1'b1, {i, 2'b00}, s, d, q);
   endtask

   task automatic rd(input logic [5:0] i, input logic [31:0] e);
      wb_host_model_i.xfer(1'b0, {i, 2'b00}, 4'hF, 32'h0, q);
      `CHK(q, e)
   endtask

   // One sample on channel zero, checked just after the taking edge.
   task automatic smp(input thresh_bank_pkg::level_t s,
                      input logic [1:0] e, input logic m);
      @(posedge clk_i);
      sample_i[0] <= s;
      edge_en_i[0] <= e;
      mode_i[0] <= m;
      sample_valid_i[0] <= 1'b1;
      @(posedge clk_i);
      sample_valid_i[0] <= 1'b0;
      #1;
   endtask

   task automatic t_reset;
      rd(`IDX_LOW_MAP, 32'h0);
      rd(`IDX_MID_MAP, 32'h0);
      rd(`IDX_SUPPLY_MAP, 32'h0);
      $display("reset test done");
   endtask

   task automatic t_fields;
      wr(`IDX_SIX_SEVEN, 32'hFFFFFFFF, 4'hF);
      rd(`IDX_SIX_SEVEN, 32'h000FFFFF);
      wr(`IDX_SIX_SEVEN, {12'h0, 10'h2A5, 10'h15A}, 4'hF);
      rd(`IDX_SIX_SEVEN, {12'h0, 10'h2A5, 10'h15A});
      wr(`IDX_EIGHT_NINE, {12'h0, 10'h3C3, 10'h2F0}, 4'hF);
      wr(`IDX_EIGHT_NINE, 32'h0, 4'h1);
      `CHK(threshold_eight_o, 10'h200)
      `CHK(threshold_nine_o, 10'h3C3)
      rd(`IDX_EIGHT_NINE, {12'h0, 10'h3C3, 10'h200});
      wr(`IDX_LOW_MAP, 32'hFFFFFFFF, 4'hF);
      rd(`IDX_LOW_MAP, 32'h00FFFFFF);
      wr(`IDX_MID_MAP, 32'hFFFFFFFF, 4'hF);
      rd(`IDX_MID_MAP, 32'h0003FFFF);
      wr(`IDX_SUPPLY_MAP, 32'hFFFFFFFF, 4'hF);
      rd(`IDX_SUPPLY_MAP, 32'h001FFE00);
      wr(6'h3F, 32'hFFFFFFFF, 4'hF);
      rd(6'h3F, 32'h0);
      $display("field test done");
   endtask

   task automatic t_select;
      logic [31:0] m0, m1, m2;
      logic [2:0]  v;
      m0 = 32'h0;
      m1 = 32'h0;
      m2 = 32'h0;
      for (int k = 0; k < 8; k++) lv[k] = 10'(65 * k + 19);
      @(posedge clk_i);
      for (int k = 0; k < 6; k++) thresh_low_i[k] <= lv[k];
      wr(`IDX_SIX_SEVEN, {12'h0, lv[7], lv[6]}, 4'hF);
      for (int c = 0; c < 18; c++) begin
         v = 3'(c * 5 + 3);
         if (c < 8) m0[3*c+:3] = v;
         else if (c < 14) m1[3*(c-8)+:3] = v;
         else m2[9+3*(c-14)+:3] = v;
      end
      wr(`IDX_LOW_MAP, m0, 4'hF);
      wr(`IDX_MID_MAP, m1, 4'hF);
      wr(`IDX_SUPPLY_MAP, m2, 4'hF);
      repeat (2) @(posedge clk_i);
      for (int c = 0; c < 18; c++) begin
         `CHK(level_o[c], lv[3'(c * 5 + 3)])
      end
      $display("select test done");
   endtask

   task automatic t_cross;
      thresh_bank_pkg::level_t l;
      l = lv[3];
      for (int e = 0; e < 4; e++) begin
         smp(l, 2'(e), 1'b0);
         `CHK(above_o[0], 1'b0)
         smp(l + 10'h001, 2'(e), 1'b0);
         `CHK(above_o[0], 1'b1)
         `CHK(crossing_o[0], e[0])
         smp(l, 2'(e), 1'b0);
         `CHK(crossing_o[0], e[1])
      end
      smp(l + 10'h005, 2'h3, 1'b1);
      `CHK(code_o[0], l + 10'h005)
      `CHK(crossing_o[0], 1'b0)
      `CHK(above_o[0], 1'b0)
      smp(l + 10'h005, 2'h3, 1'b0);
      `CHK(crossing_o[0], 1'b1)
      $display("crossing test done");
   endtask

   // Prints the counts and the verdict, then stops.
   task automatic end_of_test;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Stops a hung run well after the tests should have ended.
   initial begin
      #100000;
      miscompares++;
      $display("watchdog expired");
      end_of_test;
   end

   // Reset, then the scenarios in order.
   initial begin
      compares = 0;
      miscompares = 0;
      rst_i = 1'b1;
      thresh_low_i = '0;
      sample_i = '0;
      sample_valid_i = '0;
      edge_en_i = '0;
      mode_i = '0;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset;
      t_fields;
      t_select;
      t_cross;
      end_of_test;
   end
endmodule

// File: test/wb_host_model.sv
`timescale 1ns/1ns

module wb_host_model (
   input  wire logic        clk_i,  // Clock.
   input  wire logic        ack_i,  // Acknowledge.
   input  wire logic [31:0] rdat_i, // Read data.
   output logic             cyc_o,  // Cycle.
   output logic             stb_o,  // Strobe.
   output logic             we_o,   // Write enable.
   output logic [7:0]       adr_o,  // Byte address.
   output logic [3:0]       sel_o,  // Byte enables.
   output logic [31:0]      dat_o   // Write data.
);
   // The bus is idle at time zero.
   initial begin
      cyc_o = 1'b0;
      stb_o = 1'b0;
      we_o  = 1'b0;
      adr_o = 8'h00;
      sel_o = 4'h0;
      dat_o = 32'h0;
   end

   // One classic cycle, held until ack is seen at a rising edge.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [3:0] s, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk_i);
      cyc_o <= 1'b1;
      stb_o <= 1'b1;
      we_o  <= w;
      adr_o <= a;
      sel_o <= s;
      dat_o <= d;
      // Waits for the answer; only the bench watchdog ends a hung wait.
      @(posedge clk_i);
      while (ack_i !== 1'b1) begin
         @(posedge clk_i);
      end
      q = rdat_i;
      cyc_o <= 1'b0;
      stb_o <= 1'b0;
      dat_o <= ~d; // Released data must not keep its old value.
   endtask
endmodule
